/* design/sas_consts.svh */
// Constants for the converter sequencer: register indices, field positions, timing.
// Assumes a 20 MHz core clock and an 8-bit byte-wide register port.
// Operation
// - Result stored in bits 6 to 15
// - Six low result bits read zero
// - Upper-byte read latches lower byte for later
// - Group bits pick inputs; code 11 prohibited
// - Twelve inputs, three groups of four
// - Single mode and scan of 1-4 channels
// - Start by software, timer or pin
// - Each conversion takes 13.3 us
// - End flag bit 7 set at end
// - Flag clears by zero after one read
// - Transfer controller result read clears flag
// - Bit 6 enables end interrupt
// - Halt bit stops converter and registers
// - Writing go bit 1 starts conversion
// - Writing go bit 0 stops, waits
// - Single clears go; scan repeats until stopped
// - Bit 4 selects single or scan
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH
`define SAS_IDX_RESULT_A_HI 4'h0
`define SAS_IDX_RESULT_D_LO 4'h7
`define SAS_IDX_CSR 4'h8
`define SAS_CSR_FLAG 7
`define SAS_CSR_IE 6
`define SAS_CSR_GO 5
`define SAS_CSR_SCAN 4
`define SAS_CSR_GROUP_MSB 3
`define SAS_CSR_GROUP_LSB 2
`define SAS_CSR_CHAN_MSB 1
`define SAS_CSR_CHAN_LSB 0
`define SAS_CSR_RESET 8'h00
`define SAS_RESULT_LSB 6
`define SAS_GROUP_BAD 2'h3
`define SAS_CONV_TIME_PS 13300000
`define SAS_CLK_PERIOD_PS 50000
`define SAS_CONV_CYCLES (`SAS_CONV_TIME_PS / `SAS_CLK_PERIOD_PS)
`endif

/* design/sas_cycle_timer.sv */
// Conversion period counter: one done pulse LIMIT cycles after start.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
`include "sas_consts.svh"
module sas_cycle_timer
  import sas_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] LIMIT = WIDTH'(`SAS_CONV_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic run_q;
  logic run_d;
  logic done_d;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (abort)
    begin
      run_d = 1'b0;
    end
    else if (start)
    begin
      run_d = 1'b1;
      cnt_d = WIDTH'(1);
    end
    else if (run_q)
    begin
      if (cnt_q == LIMIT - WIDTH'(1))
      begin
        done_d = 1'b1;
        run_d = 1'b0;
      end
      cnt_d = cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done <= done_d;
    end
  end
endmodule : sas_cycle_timer

/* design/sas_pkg.sv */
// Types shared by the converter sequencer modules.
// Assumes sas_consts.svh supplies the numeric layout.
package sas_pkg;
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic go;
    logic scan;
    logic [1:0] group;
    logic [1:0] chan;
  } sas_csr_t;

  typedef enum logic [1:0] {
    SAS_WAIT = 2'b01,
    SAS_CONV = 2'b10
  } sas_state_t;
endpackage : sas_pkg

/* design/sas_top.sv */
// Sequencer for a 10-bit successive-approximation converter with 12 inputs.
// Assumes the analog side returns a finished code on CONV_DATA when asked,
// and that bus strobes are one-cycle pulses on CORE_CLK.
`timescale 1ns/1ns
`include "sas_consts.svh"
module sas_top
  import sas_pkg::*;
#(
  parameter int RES_BITS = 10,
  parameter int CHANNELS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CONVERTER_HALT,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [3:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic DTC_READ,
  input wire logic TIMER_TRIG,
  input wire logic EXT_TRIG,
  input wire logic [RES_BITS-1:0] CONV_DATA,
  output logic [7:0] BUS_RDATA,
  output logic [3:0] ANALOG_CHANNEL,
  output logic SAMPLE_START,
  output logic CONVERSION_END_IRQ
);
  sas_csr_t csr_q;
  sas_csr_t csr_d;
  sas_state_t state_q;
  sas_state_t state_d;
  logic [1:0] cur_q;
  logic [1:0] cur_d;
  logic [RES_BITS-1:0] result_q [CHANNELS];
  logic [RES_BITS-1:0] result_d [CHANNELS];
  logic [7:0] temp_q;
  logic [7:0] temp_d;
  logic [7:0] rdata_d;
  logic armed_q;
  logic armed_d;
  logic sample_d;
  logic irq_d;
  logic [3:0] chan_out_d;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic [RES_BITS-1:0] data_meta_q;
  logic [RES_BITS-1:0] data_sync_q;
  logic conv_done;
  logic [15:0] word;
  logic [1:0] rsel;
  logic last_chan;

  // Pin inputs pass two flops before use
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      data_meta_q <= '0;
      data_sync_q <= '0;
    end
    else
    begin
      ext_meta_q <= EXT_TRIG;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      data_meta_q <= CONV_DATA;
      data_sync_q <= data_meta_q;
    end
  end

  sas_cycle_timer #(
    .WIDTH(9)
  ) u_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .start(sample_d),
    .abort(state_d == SAS_WAIT),
    .done(conv_done)
  );

  always_comb
  begin
    rsel = BUS_ADDR[2:1];
    word = {result_q[rsel], {`SAS_RESULT_LSB{1'b0}}};
    last_chan = csr_q.scan ? (cur_q == csr_q.chan) : 1'b1;
    csr_d = csr_q;
    state_d = state_q;
    cur_d = cur_q;
    temp_d = temp_q;
    armed_d = armed_q;
    rdata_d = 8'h00;
    sample_d = 1'b0;
    for (int i = 0; i < CHANNELS; i++)
    begin
      result_d[i] = result_q[i];
    end
    // Register reads
    if (BUS_RD && !CONVERTER_HALT)
    begin
      if (BUS_ADDR == `SAS_IDX_CSR)
      begin
        rdata_d = csr_q;
        if (csr_q.flag)
        begin
          armed_d = 1'b1;
        end
      end
      else if (BUS_ADDR <= `SAS_IDX_RESULT_D_LO)
      begin
        if (BUS_ADDR[0] == 1'b0)
        begin
          rdata_d = word[15:8];
          temp_d = word[7:0];
        end
        else
        begin
          rdata_d = temp_q;
        end
        if (DTC_READ)
        begin
          csr_d.flag = 1'b0;
        end
      end
    end
    // Register writes
    if (BUS_WR && !CONVERTER_HALT && BUS_ADDR == `SAS_IDX_CSR)
    begin
      csr_d.irq_en = BUS_WDATA[`SAS_CSR_IE];
      csr_d.scan = BUS_WDATA[`SAS_CSR_SCAN];
      csr_d.group = BUS_WDATA[`SAS_CSR_GROUP_MSB:`SAS_CSR_GROUP_LSB];
      csr_d.chan = BUS_WDATA[`SAS_CSR_CHAN_MSB:`SAS_CSR_CHAN_LSB];
      csr_d.go = BUS_WDATA[`SAS_CSR_GO];
      if (!BUS_WDATA[`SAS_CSR_FLAG] && armed_q)
      begin
        csr_d.flag = 1'b0;
        armed_d = 1'b0;
      end
    end
    // Hardware triggers act like a software start
    if (TIMER_TRIG || (ext_sync_q && !ext_prev_q))
    begin
      csr_d.go = 1'b1;
    end
    // Prohibited group code never starts a conversion
    if (csr_d.group == `SAS_GROUP_BAD)
    begin
      csr_d.go = 1'b0;
    end
    unique case (state_q)
      SAS_WAIT:
      begin
        if (csr_d.go)
        begin
          state_d = SAS_CONV;
          cur_d = csr_d.scan ? 2'h0 : csr_d.chan;
          sample_d = 1'b1;
        end
      end
      SAS_CONV:
      begin
        if (!csr_d.go)
        begin
          state_d = SAS_WAIT;
        end
        else if (conv_done)
        begin
          result_d[cur_q] = data_sync_q;
          if (last_chan)
          begin
            csr_d.flag = 1'b1;
          end
          if (!csr_q.scan)
          begin
            csr_d.go = 1'b0;
            state_d = SAS_WAIT;
          end
          else
          begin
            cur_d = last_chan ? 2'h0 : cur_q + 2'h1;
            sample_d = 1'b1;
          end
        end
      end
    endcase
    // Halt forces go, the state and the sample strobe idle
    if (CONVERTER_HALT)
    begin
      csr_d.go = 1'b0;
      state_d = SAS_WAIT;
      sample_d = 1'b0;
    end
    // Never steer the mux to the missing fourth group
    chan_out_d = ANALOG_CHANNEL;
    if (csr_d.group != `SAS_GROUP_BAD)
    begin
      chan_out_d = {csr_d.group, cur_d};
    end
    irq_d = csr_d.flag && csr_d.irq_en;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      csr_q <= `SAS_CSR_RESET;
      state_q <= SAS_WAIT;
      cur_q <= 2'h0;
      temp_q <= 8'h00;
      armed_q <= 1'b0;
      BUS_RDATA <= 8'h00;
      ANALOG_CHANNEL <= 4'h0;
      SAMPLE_START <= 1'b0;
      CONVERSION_END_IRQ <= 1'b0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        result_q[i] <= '0;
      end
    end
    else
    begin
      csr_q <= csr_d;
      state_q <= state_d;
      cur_q <= cur_d;
      temp_q <= temp_d;
      armed_q <= armed_d;
      BUS_RDATA <= rdata_d;
      ANALOG_CHANNEL <= chan_out_d;
      SAMPLE_START <= sample_d;
      CONVERSION_END_IRQ <= irq_d;
      for (int i = 0; i < CHANNELS; i++)
      begin
        result_q[i] <= result_d[i];
      end
    end
  end
endmodule : sas_top

/* sim/sas_analog_model.sv */
// Analog side: a code per input number, held through one conversion.
// Assumes SAMPLE_START marks each new sample.
`timescale 1ns/1ns
module sas_analog_model (
  input wire logic clk,
  input wire logic sample,
  input wire logic [3:0] chan,
  output logic [9:0] code
);
  logic [8:0] age = 9'h1ff;
  logic [9:0] held = 10'h000;
  always @(posedge clk)
  begin
    if (sample)
      held <= {chan, 6'h2d};
    age <= sample ? 9'h000 : age + {8'h00, age != 9'h1ff};
  end
  // Toggles once the hold runs out, so a late sample never matches
  assign code = (age < 9'h113) ? held : ~held ^ {9'h000, age[0]};
endmodule : sas_analog_model

/* sim/sas_monitor.sv */
// Port checker for the converter sequencer.
// Assumes a bind onto sas_top; watches its ports only.
`timescale 1ns/1ns
module sas_monitor (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CONVERTER_HALT,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [3:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic [3:0] ANALOG_CHANNEL,
  input wire logic SAMPLE_START,
  input wire logic CONVERSION_END_IRQ
);
  logic ie_q;
  logic ie_d;
  logic [8:0] gap_q;
  logic [8:0] gap_d;
  wire csr_rd = BUS_RD && !CONVERTER_HALT && BUS_ADDR == 4'h8;
  // A stop allows an early restart, so the gap count jumps to its 9'h1ff ceiling
  wire stop_req = CONVERTER_HALT || (BUS_WR && BUS_ADDR == 4'h8
    && (!BUS_WDATA[5] || BUS_WDATA[3:2] == 2'h3));
  // Shadow of the enable bit, since the flag itself is not visible
  always_comb
  begin
    ie_d = ie_q;
    if (BUS_WR && !CONVERTER_HALT && BUS_ADDR == 4'h8)
      ie_d = BUS_WDATA[6];
    gap_d = SAMPLE_START ? 9'h000 : (stop_req ? 9'h1ff : gap_q + {8'h00, gap_q != 9'h1ff});
  end
  always_ff @(posedge CORE_CLK)
  begin
    ie_q <= RST ? 1'b0 : ie_d;
    gap_q <= RST ? 9'h1ff : gap_d;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_rdata_idle: assert property (!$past(BUS_RD) |-> BUS_RDATA == 8'h00)
    else $error("read data not idle");
  chk_halt_read: assert property ($past(BUS_RD && CONVERTER_HALT) |-> BUS_RDATA == 8'h00)
    else $error("read while halted");
  chk_low_zero: assert property ($past(BUS_RD && BUS_ADDR[0] && !BUS_ADDR[3])
    |-> BUS_RDATA[5:0] == 6'h00)
    else $error("low bits not zero");
  chk_group_legal: assert property (ANALOG_CHANNEL[3:2] != 2'h3)
    else $error("bad group");
  chk_start_pulse: assert property (SAMPLE_START |=> !SAMPLE_START)
    else $error("long start");
  chk_conv_gap: assert property (SAMPLE_START |-> gap_q >= 9'h108)
    else $error("conversion too short");
  chk_irq_masked: assert property (!ie_d |=> !CONVERSION_END_IRQ)
    else $error("irq while masked");
  chk_flag_irq: assert property (csr_rd && ie_q |=> BUS_RDATA[7] == $past(CONVERSION_END_IRQ))
    else $error("irq differs from flag");
  cover property (SAMPLE_START);
  cover property ($rose(CONVERSION_END_IRQ));
  cover property (BUS_RD && CONVERTER_HALT);
endmodule : sas_monitor
bind sas_top sas_monitor mon (.*);

/* sim/testbench.sv */
// Self-checking bench for the converter sequencer.
// Assumes the analog model and the bound port checker.
`timescale 1ns/1ns
module testbench;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic CONVERTER_HALT = 1'b0, BUS_RD = 1'b0, BUS_WR = 1'b0, DTC_READ = 1'b0;
  logic TIMER_TRIG = 1'b0, EXT_TRIG = 1'b0, SAMPLE_START, CONVERSION_END_IRQ;
  logic [3:0] BUS_ADDR = 4'h0;
  logic [3:0] ANALOG_CHANNEL;
  logic [7:0] BUS_WDATA = 8'h00;
  logic [7:0] BUS_RDATA;
  logic [7:0] v;
  logic [9:0] CONV_DATA;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  sas_top uut (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .CONVERTER_HALT(CONVERTER_HALT),
    .BUS_RD(BUS_RD),
    .BUS_WR(BUS_WR),
    .BUS_ADDR(BUS_ADDR),
    .BUS_WDATA(BUS_WDATA),
    .DTC_READ(DTC_READ),
    .TIMER_TRIG(TIMER_TRIG),
    .EXT_TRIG(EXT_TRIG),
    .CONV_DATA(CONV_DATA),
    .BUS_RDATA(BUS_RDATA),
    .ANALOG_CHANNEL(ANALOG_CHANNEL),
    .SAMPLE_START(SAMPLE_START),
    .CONVERSION_END_IRQ(CONVERSION_END_IRQ)
  );
  sas_analog_model far (.clk(CORE_CLK), .sample(SAMPLE_START), .chan(ANALOG_CHANNEL),
    .code(CONV_DATA));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #5;
  endtask : tick
  task automatic bw(input logic [3:0] a, input logic [7:0] d);
    BUS_ADDR = a;
    BUS_WDATA = d;
    BUS_WR = 1'b1;
    tick(1);
    BUS_WR = 1'b0;
    tick(1);
  endtask : bw
  task automatic br(input logic [3:0] a);
    BUS_ADDR = a;
    BUS_RD = 1'b1;
    tick(1);
    BUS_RD = 1'b0;
    v = BUS_RDATA;
    tick(1);
  endtask : br
  task automatic wait_irq;
    // A four-channel scan pass needs over a thousand cycles
    for (int i = 0; i < 1200 && CONVERSION_END_IRQ !== 1'b1; i++)
      tick(1);
    chk({7'h00, CONVERSION_END_IRQ}, 8'h01);
  endtask : wait_irq
  task automatic t_single;
    br(4'h8);
    chk(v, 8'h00);
    for (int g = 0; g < 3; g++)
      for (int c = 0; c < 4; c++)
      begin
        bw(4'h8, {4'h6, g[1:0], c[1:0]});
        wait_irq();
        br(4'h8);
        chk(v, {4'hc, g[1:0], c[1:0]});
        bw(4'h8, {4'h4, g[1:0], c[1:0]});
        chk({7'h00, CONVERSION_END_IRQ}, 8'h00);
        br({c[2:0], 1'b0});
        chk(v, {g[1:0], c[1:0], 4'hb});
        br({c[2:0], 1'b1});
        chk(v, 8'h40);
      end
    $display("single done");
  endtask : t_single
  task automatic t_scan;
    bw(4'h8, 8'h77);
    wait_irq();
    for (int c = 0; c < 4; c++)
    begin
      br({c[2:0], 1'b0});
      chk(v, {4'h4 + c[3:0], 4'hb});
    end
    br(4'h8);
    chk(v, 8'hf7);
    bw(4'h8, 8'h57);
    tick(300);
    br(4'h8);
    chk(v, 8'h57);
    $display("scan done");
  endtask : t_scan
  task automatic t_trig;
    bw(4'h8, 8'h40);
    TIMER_TRIG = 1'b1;
    tick(1);
    TIMER_TRIG = 1'b0;
    wait_irq();
    DTC_READ = 1'b1;
    br(4'h0);
    DTC_READ = 1'b0;
    chk({7'h00, CONVERSION_END_IRQ}, 8'h00);
    EXT_TRIG = 1'b1;
    tick(3);
    EXT_TRIG = 1'b0;
    wait_irq();
    br(4'h8);
    chk(v, 8'hc0);
    $display("trigger done");
  endtask : t_trig
  task automatic t_halt;
    bw(4'h8, 8'h80);
    br(4'h8);
    chk(v, 8'h80);
    bw(4'h8, 8'h6c);
    br(4'h8);
    chk({7'h00, v[5]}, 8'h00);
    bw(4'h8, 8'h60);
    tick(10);
    CONVERTER_HALT = 1'b1;
    br(4'h8);
    chk(v, 8'h00);
    bw(4'h8, 8'h60);
    CONVERTER_HALT = 1'b0;
    tick(300);
    br(4'h8);
    chk(v, 8'h40);
    $display("halt done");
  endtask : t_halt
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    tick(2);
    RST = 1'b0;
    t_single();
    t_scan();
    t_trig();
    t_halt();
    final_report();
  end
endmodule : testbench
